/* hw/mtu_link_ser.sv */
// link-domain serializer: one bit per link clock edge
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module mtu_link_ser (
  // link clock and reset
  input wire logic clk_link,
  input wire logic reset_n,
  // from the system domain
  input wire logic req_tgl,
  input wire logic [7:0] xfer_data,
  input wire logic xfer_alt,
  input wire mtu_pkg::mtu_cfg_t cfg_in,
  // to the system domain
  output logic ack_tgl,
  output logic under_tgl,
  // to the modulator
  output logic tx_bit,
  output logic tx_active
);
  import mtu_pkg::*;
  typedef struct packed {
    mtu_ser_state_t state;
    logic [2:0] cnt;
    logic [1:0] stop_left;
    logic [7:0] shift;
    logic alt;
    logic [7:0] slot_data;
    logic slot_alt;
    logic slot_full;
    logic seen_req;
    logic under_tgl;
    logic primed;
    logic starved;
    logic pat;
    logic bit_out;
    logic active;
    logic [CFG_W-1:0] cfg_last;
    logic [CFG_W-1:0] cfg_ok;
  } mtu_link_state_t;
  mtu_link_state_t st_ff;
  mtu_link_state_t nxt_st;
  logic [CFG_W:0] sync_q;
  mtu_cfg_t cfg;
  mtu_txmode_t md;
  logic req_s;
  logic dpsk;
  logic run;
  logic [2:0] last_bit;
  logic [7:0] mask;
  logic par_bit;
  logic [1:0] stops;
  mtu_sync #(.WIDTH(CFG_W + 1)) u_sync (
    .clk(clk_link),
    .reset_n(reset_n),
    .d({req_tgl, cfg_in}),
    .q(sync_q)
  );
  always_comb begin
    req_s = sync_q[CFG_W];
    cfg = st_ff.cfg_ok;
    md = {3'h0, cfg.txmode};
    dpsk = (md.mode == MODE_DPSK_1200) || (md.mode == MODE_DPSK_600);
    // modem transmit modes only; standby stops the serializer, but the buffer slot still takes handed-over words
    run = !cfg.standby && (md.mode >= MODE_DPSK_1200) && (md.mode <= MODE_FSK_B202_150);
    last_bit = {1'b0, md.nbits} + 3'h4;
    mask = 8'hff >> (2'h3 - md.nbits);
    par_bit = (^(st_ff.shift & mask)) ^ md.par_odd;
    stops = {1'b0, ~md.two_stop} + {md.two_stop, 1'b0};
    if (st_ff.alt && dpsk && md.style == STYLE_ASYNC) begin
      stops = 2'(stops - 2'h1);
    end
  end
  always_comb begin
    nxt_st = st_ff;
    nxt_st.active = run;
    // config word is taken only once it held still for a cycle, so bit skew is never decoded
    nxt_st.cfg_last = sync_q[CFG_W-1:0];
    if (sync_q[CFG_W-1:0] == st_ff.cfg_last) begin
      nxt_st.cfg_ok = st_ff.cfg_last;
    end
    // buffer slot takes the word handed over by the system side
    if ((req_s != st_ff.seen_req) && !st_ff.slot_full) begin
      nxt_st.slot_data = xfer_data;
      nxt_st.slot_alt = xfer_alt;
      nxt_st.slot_full = 1'b1;
      nxt_st.seen_req = req_s;
    end
    if (!run) begin
      nxt_st.bit_out = 1'b1;
      nxt_st.state = ST_IDLE;
    end else if (md.style == STYLE_PATTERN) begin
      nxt_st.state = ST_IDLE;
      case (md.pattern)
        PAT_ONES: nxt_st.bit_out = 1'b1;
        PAT_ZEROS: nxt_st.bit_out = 1'b0;
        default: begin
          nxt_st.pat = ~st_ff.pat;
          nxt_st.bit_out = st_ff.pat;
        end
      endcase
    end else begin
      case (st_ff.state)
        ST_IDLE: begin
          if (st_ff.slot_full) begin
            nxt_st.shift = st_ff.slot_data;
            nxt_st.alt = st_ff.slot_alt;
            nxt_st.slot_full = 1'b0;
            nxt_st.primed = 1'b1;
            nxt_st.starved = 1'b0;
            nxt_st.state = ST_DATA;
            if (md.style == STYLE_ASYNC) begin
              nxt_st.bit_out = 1'b0;
              nxt_st.cnt = 3'h0;
            end else begin
              nxt_st.bit_out = st_ff.slot_data[0];
              nxt_st.cnt = 3'h1;
            end
          end else if (md.style == STYLE_ASYNC) begin
            nxt_st.bit_out = 1'b1;
            if (st_ff.primed && !st_ff.starved) begin
              nxt_st.under_tgl = ~st_ff.under_tgl;
              nxt_st.starved = 1'b1;
            end
          end else if (!st_ff.primed) begin
            // nothing sent since reset: hold the line at the idle level
            nxt_st.bit_out = 1'b1;
          end else begin
            // resend the old buffer
            nxt_st.bit_out = st_ff.shift[0];
            nxt_st.cnt = 3'h1;
            nxt_st.state = ST_DATA;
            nxt_st.under_tgl = ~st_ff.under_tgl;
          end
        end
        ST_DATA: begin
          nxt_st.bit_out = st_ff.shift[st_ff.cnt];
          nxt_st.cnt = 3'(st_ff.cnt + 3'h1);
          if (md.style != STYLE_ASYNC) begin
            if (st_ff.cnt == SYNC_LAST_BIT) begin
              nxt_st.state = ST_IDLE;
            end
          end else if (st_ff.cnt == last_bit) begin
            nxt_st.cnt = 3'h0;
            nxt_st.stop_left = stops;
            if (md.par_en) begin
              nxt_st.state = ST_PARITY;
            end else if (stops != 2'h0) begin
              nxt_st.state = ST_STOP;
            end else begin
              nxt_st.state = ST_IDLE;
            end
          end
        end
        ST_PARITY: begin
          nxt_st.bit_out = par_bit;
          nxt_st.state = (stops != 2'h0) ? ST_STOP : ST_IDLE;
          nxt_st.stop_left = stops;
        end
        ST_STOP: begin
          nxt_st.bit_out = 1'b1;
          nxt_st.stop_left = 2'(st_ff.stop_left - 2'h1);
          if (st_ff.stop_left <= 2'h1) begin
            nxt_st.state = ST_IDLE;
          end
        end
        default: begin
          nxt_st.state = ST_IDLE;
          nxt_st.bit_out = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.bit_out <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign ack_tgl = st_ff.seen_req;
  assign under_tgl = st_ff.under_tgl;
  assign tx_bit = st_ff.bit_out;
  assign tx_active = st_ff.active;
endmodule
`default_nettype wire

/* hw/mtu_pkg.sv */
// package: shared constants and types of the modem transmit usart
package mtu_pkg;
  // ==========================================================
  // register bus
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_GENCTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_TXMODE = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_RXMODE = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_TXDATA_ALT = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h5;
  // ==========================================================
  // field positions and reset values
  localparam int GEN_STANDBY_BIT = 0;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_UNDER_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam logic [DATA_W-1:0] TXMODE_MASK = 16'h1fff;
  localparam logic [DATA_W-1:0] TXMODE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RXMODE_RST = 16'h0000;
  localparam logic READY_RST = 1'b1;
  localparam logic [2:0] SYNC_LAST_BIT = 3'h7;
  localparam logic [1:0] NBITS_BASE_M1 = 2'h0;
  // ==========================================================
  // transmit modes
  typedef enum logic [3:0] {
    MODE_DISABLED = 4'h0,
    MODE_DPSK_1200 = 4'h1,
    MODE_DPSK_600 = 4'h2,
    MODE_FSK_V21 = 4'h3,
    MODE_FSK_B103 = 4'h4,
    MODE_FSK_V23_1200 = 4'h5,
    MODE_FSK_V23_75 = 4'h6,
    MODE_FSK_B202_1200 = 4'h7,
    MODE_FSK_B202_150 = 4'h8,
    MODE_DTMF = 4'h9,
    MODE_TONE = 4'ha,
    MODE_TONE_PAIR = 4'hb
  } mtu_mode_t;
  typedef enum logic [1:0] {
    STYLE_PATTERN = 2'h0,
    STYLE_ASYNC = 2'h1,
    STYLE_SYNC = 2'h2
  } mtu_style_t;
  typedef enum logic [1:0] {
    PAT_ONES = 2'h0,
    PAT_ZEROS = 2'h1,
    PAT_ALT = 2'h2
  } mtu_pattern_t;
  // transmit mode register layout
  typedef struct packed {
    logic [2:0] rsv;
    logic [1:0] pattern;
    logic two_stop;
    logic par_odd;
    logic par_en;
    logic [1:0] nbits;
    logic [1:0] style;
    logic [3:0] mode;
  } mtu_txmode_t;
  // configuration carried into the link domain
  typedef struct packed {
    logic standby;
    logic [12:0] txmode;
  } mtu_cfg_t;
  localparam int CFG_W = 14;
  // serializer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DATA = 5'h02,
    ST_PARITY = 5'h04,
    ST_STOP = 5'h08,
    ST_SPARE = 5'h10
  } mtu_ser_state_t;
endpackage

/* hw/mtu_sync.sv */
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module mtu_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } mtu_sync_state_t;
  mtu_sync_state_t st_ff;
  mtu_sync_state_t nxt_st;
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.s2;
endmodule
`default_nettype wire

/* hw/mtu_tx_usart.sv */
// top of the modem transmit usart: register port, holding register, hand-over to the link serializer
`timescale 1ns/1ps
`default_nettype none
module mtu_tx_usart (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [mtu_pkg::ADDR_W-1:0] addr,
  input wire logic [mtu_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [mtu_pkg::DATA_W-1:0] rd_data,
  // configuration towards modulator and receiver
  output logic [mtu_pkg::DATA_W-1:0] tx_mode_cfg,
  output logic [mtu_pkg::DATA_W-1:0] rx_mode_cfg,
  output logic standby,
  // link side
  input wire logic clk_link,
  output logic tx_bit,
  output logic tx_active
);
  import mtu_pkg::*;
  // ==========================================================
  // state
  typedef struct packed {
    logic [DATA_W-1:0] txmode;
    logic [DATA_W-1:0] rxmode;
    logic standby;
    logic [7:0] hold;
    logic hold_alt;
    logic hold_full;
    logic [7:0] xfer;
    logic xfer_alt;
    logic req_tgl;
    logic ready;
    logic under;
    logic under_seen;
    logic [DATA_W-1:0] rdata;
  } mtu_sys_state_t;
  mtu_sys_state_t st_ff;
  mtu_sys_state_t nxt_st;
  logic ack_tgl;
  logic under_tgl;
  logic [1:0] back_s;
  logic link_free;
  logic data_wr;
  logic under_evt;
  mtu_txmode_t md;
  mtu_cfg_t cfg;
  // ==========================================================
  // crossings back from the link domain
  mtu_sync #(.WIDTH(2)) u_back_sync (
    .clk(clk_sys),
    .reset_n(reset_n),
    .d({ack_tgl, under_tgl}),
    .q(back_s)
  );
  // ==========================================================
  // register and hand-over logic
  always_comb begin
    nxt_st = st_ff;
    md = st_ff.txmode;
    link_free = (back_s[1] == st_ff.req_tgl);
    under_evt = (back_s[0] != st_ff.under_seen);
    data_wr = wr_en && ((addr == OFS_TXDATA) || (addr == OFS_TXDATA_ALT));
    nxt_st.rdata = '0;
    if (wr_en) begin
      case (addr)
        OFS_GENCTRL: nxt_st.standby = wr_data[GEN_STANDBY_BIT];
        OFS_TXMODE: nxt_st.txmode = wr_data & TXMODE_MASK;
        OFS_RXMODE: nxt_st.rxmode = wr_data;
        OFS_TXDATA, OFS_TXDATA_ALT: begin
          nxt_st.hold = wr_data[7:0];
          // alternate address counts as normal outside start-stop
          nxt_st.hold_alt = (addr == OFS_TXDATA_ALT) && (md.style == STYLE_ASYNC);
          nxt_st.hold_full = 1'b1;
          nxt_st.ready = 1'b0;
        end
        OFS_STATUS: begin
          if (wr_data[STAT_UNDER_BIT]) begin
            nxt_st.under = 1'b0;
          end
        end
        default: begin
          nxt_st.hold_full = st_ff.hold_full;
        end
      endcase
    end
    // hand the word to the buffer side; a data write in the same cycle holds the hand-over back one cycle
    if (st_ff.hold_full && link_free && !data_wr) begin
      nxt_st.xfer = st_ff.hold;
      nxt_st.xfer_alt = st_ff.hold_alt;
      nxt_st.req_tgl = ~st_ff.req_tgl;
      nxt_st.hold_full = 1'b0;
      nxt_st.ready = 1'b1;
    end
    // set wins over the software clear
    if (under_evt) begin
      nxt_st.under = 1'b1;
      nxt_st.under_seen = back_s[0];
    end
    if (rd_en) begin
      case (addr)
        OFS_GENCTRL: nxt_st.rdata = {15'h0000, st_ff.standby};
        OFS_TXMODE: nxt_st.rdata = st_ff.txmode;
        OFS_RXMODE: nxt_st.rdata = st_ff.rxmode;
        OFS_TXDATA, OFS_TXDATA_ALT: nxt_st.rdata = {8'h00, st_ff.hold};
        OFS_STATUS: begin
          nxt_st.rdata[STAT_READY_BIT] = st_ff.ready;
          nxt_st.rdata[STAT_UNDER_BIT] = st_ff.under;
          nxt_st.rdata[STAT_FULL_BIT] = st_ff.hold_full;
        end
        default: nxt_st.rdata = '0;
      endcase
    end
    cfg.standby = st_ff.standby;
    cfg.txmode = st_ff.txmode[12:0];
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.txmode <= TXMODE_RST;
      st_ff.rxmode <= RXMODE_RST;
      st_ff.ready <= READY_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ==========================================================
  // link-domain serializer
  mtu_link_ser u_ser (
    .clk_link(clk_link),
    .reset_n(reset_n),
    .req_tgl(st_ff.req_tgl),
    .xfer_data(st_ff.xfer),
    .xfer_alt(st_ff.xfer_alt),
    .cfg_in(cfg),
    .ack_tgl(ack_tgl),
    .under_tgl(under_tgl),
    .tx_bit(tx_bit),
    .tx_active(tx_active)
  );
  assign rd_data = st_ff.rdata;
  assign tx_mode_cfg = st_ff.txmode;
  assign rx_mode_cfg = st_ff.rxmode;
  assign standby = st_ff.standby;
endmodule
`default_nettype wire

/* sim/mtu_line_mon.sv */
// modulator side model: records the serial line from its first low bit
`timescale 1ns/1ps
`default_nettype none
module mtu_line_mon (
  // link clock and reset
  input wire logic clk_link,
  input wire logic reset_n,
  // capture control and line
  input wire logic arm,
  input wire logic tx_bit,
  output logic [127:0] bits,
  output logic [7:0] cnt
);
  logic run;
  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      cnt <= 8'h00;
      bits <= '0;
    end else if (!arm) begin
      run <= 1'b0;
      cnt <= 8'h00;
      bits <= '0;
    end else if ((run || !tx_bit) && !cnt[7]) begin
      // one line bit per link edge, lsb of the record first
      run <= 1'b1;
      bits[cnt[6:0]] <= tx_bit;
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* sim/mtu_tx_usart_sva.sv */
// port checker of the modem transmit usart
`timescale 1ns/1ps
`default_nettype none
module mtu_tx_usart_sva (
  // system side
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [mtu_pkg::ADDR_W-1:0] addr,
  input wire logic [mtu_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [mtu_pkg::DATA_W-1:0] rd_data,
  input wire logic [mtu_pkg::DATA_W-1:0] tx_mode_cfg,
  input wire logic [mtu_pkg::DATA_W-1:0] rx_mode_cfg,
  input wire logic standby,
  // link side
  input wire logic clk_link,
  input wire logic tx_bit,
  input wire logic tx_active
);
  import mtu_pkg::*;
  // ==========================================================
  // system domain
  property p_rd_idle;
    @(posedge clk_sys) disable iff (!reset_n) !$past(rd_en) |-> rd_data == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
  property p_txmode_wr;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_en && addr == OFS_TXMODE |=> tx_mode_cfg == ($past(wr_data) & TXMODE_MASK);
  endproperty
  a_txmode_wr: assert property (p_txmode_wr) else $error("transmit mode not stored");
  property p_txmode_rsv;
    @(posedge clk_sys) disable iff (!reset_n) tx_mode_cfg[15:13] == 3'h0;
  endproperty
  a_txmode_rsv: assert property (p_txmode_rsv) else $error("transmit mode spare bits set");
  property p_rxmode_wr;
    @(posedge clk_sys) disable iff (!reset_n) wr_en && addr == OFS_RXMODE |=> rx_mode_cfg == $past(wr_data);
  endproperty
  a_rxmode_wr: assert property (p_rxmode_wr) else $error("receive mode not stored");
  property p_rx_indep;
    @(posedge clk_sys) disable iff (!reset_n) wr_en && addr == OFS_TXMODE |=> $stable(rx_mode_cfg);
  endproperty
  a_rx_indep: assert property (p_rx_indep) else $error("receive mode moved on transmit write");
  property p_standby_wr;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_en && addr == OFS_GENCTRL |=> standby == $past(wr_data[GEN_STANDBY_BIT]);
  endproperty
  a_standby_wr: assert property (p_standby_wr) else $error("standby bit not stored");
  // ==========================================================
  // link domain
  property p_standby_stop;
    @(posedge clk_link) disable iff (!reset_n) standby [*7] |-> !tx_active;
  endproperty
  a_standby_stop: assert property (p_standby_stop) else $error("serializer runs in standby");
  property p_mode_stop;
    @(posedge clk_link) disable iff (!reset_n) !(tx_mode_cfg[3:0] inside {[4'h1:4'h8]}) [*7] |-> !tx_active;
  endproperty
  a_mode_stop: assert property (p_mode_stop) else $error("serializer runs in non modem mode");
  property p_idle_high;
    @(posedge clk_link) disable iff (!reset_n) !tx_active [*2] |-> tx_bit;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high while idle");
endmodule
`default_nettype wire

/* sim/mtu_tx_usart_tb.sv */
// self-checking bench of the modem transmit usart
`timescale 1ns/1ps
`default_nettype none
module mtu_tx_usart_tb;
  import mtu_pkg::*;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic arm = 1'b0;
  logic [DATA_W-1:0] rd_data, tx_mode_cfg, rx_mode_cfg, s;
  logic standby, tx_bit, tx_active;
  logic [127:0] bits, exp;
  logic [7:0] cnt;
  int n_exp, n_mismatch = 0, n_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  always #24 clk_link = ~clk_link;
  mtu_tx_usart dut (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .tx_mode_cfg(tx_mode_cfg), .rx_mode_cfg(rx_mode_cfg),
    .standby(standby), .clk_link(clk_link), .tx_bit(tx_bit), .tx_active(tx_active));
  mtu_line_mon mon (.clk_link(clk_link), .reset_n(reset_n), .arm(arm), .tx_bit(tx_bit), .bits(bits), .cnt(cnt));
  // ==========================================================
  // bus and compare tasks
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic lk(input int n);
    repeat (n) @(posedge clk_link);
  endtask
  task automatic add(input logic b);
    exp[n_exp] = b;
    n_exp++;
  endtask
  task automatic frm(input logic [7:0] d, input int nb, input logic par, input logic odd, input int ns);
    logic p;
    p = odd;
    add(1'b0);
    for (int i = 0; i < nb; i++) begin
      add(d[i]);
      p = p ^ d[i];
    end
    if (par) add(p);
    repeat (ns) add(1'b1);
  endtask
  task automatic start(input logic [15:0] cfg);
    wr(OFS_TXMODE, cfg);
    @(posedge clk_sys);
    arm <= 1'b0;
    lk(6);
    @(posedge clk_sys);
    arm <= 1'b1;
    n_exp = 0;
    exp = '0;
  endtask
  task automatic chk_line(input string nm);
    logic [127:0] m;
    int i;
    m = (128'h1 << n_exp) - 128'h1;
    for (i = 0; i < 3000 && cnt < n_exp; i++) @(posedge clk_link);
    if (i == 3000) begin
      n_mismatch++;
      $display("ERROR %s expected %0d bits seen %0d", nm, n_exp, cnt);
      give_verdict();
    end
    n_checks++;
    if ((bits & m) !== (exp & m)) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp & m, bits & m);
    end
  endtask
  task automatic under_clr();
    rd(OFS_STATUS, s);
    chk("underflow", 16'h0001, {15'h0, s[STAT_UNDER_BIT]});
    wr(OFS_TXMODE, 16'h0000);
    lk(8);
    wr(OFS_STATUS, 16'h0002);
    rd(OFS_STATUS, s);
    chk("underflow clear", 16'h0000, {15'h0, s[STAT_UNDER_BIT]});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(OFS_STATUS, s);
    chk("status reset", 16'h0001, s);
    wr(OFS_RXMODE, 16'ha5c3);
    wr(OFS_TXMODE, 16'hffff);
    rd(OFS_RXMODE, s);
    chk("rx mode", 16'ha5c3, s);
    rd(OFS_TXMODE, s);
    chk("tx mode", 16'h1fff, s);
    rd(3'h7, s);
    chk("unmapped", 16'h0000, s);
    wr(OFS_TXMODE, 16'h0000);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 12; m++) begin
      wr(OFS_TXMODE, 16'h0010 | 16'(m));
      lk(10);
      chk("tx active", {15'h0, m >= 1 && m <= 8}, {15'h0, tx_active});
    end
    wr(OFS_TXMODE, 16'h00d3);
    wr(OFS_GENCTRL, 16'h0001);
    lk(10);
    chk("standby active", 16'h0000, {15'h0, tx_active});
    wr(OFS_GENCTRL, 16'h0000);
    wr(OFS_TXMODE, 16'h0000);
  endtask
  task automatic t_pattern();
    start(16'h1003);
    repeat (8) begin
      add(1'b0);
      add(1'b1);
    end
    chk_line("pattern line");
    wr(OFS_TXMODE, 16'h0000);
  endtask
  task automatic t_sync();
    logic [7:0] w = 8'h96;
    start(16'h0021);
    wr(OFS_TXDATA_ALT, 16'hff96);
    // the word, then the same word again once the host misses the reload
    for (int i = 0; i < 16; i++) add(w[i[2:0]]);
    chk_line("sync line");
    under_clr();
  endtask
  task automatic t_async();
    for (int nb = 5; nb <= 8; nb++) begin
      start(16'h0113 | 16'((nb - 5) << 6) | 16'((nb & 1) << 9));
      wr(OFS_TXDATA, 16'h00a7);
      frm(8'ha7, nb, 1'b1, nb[0], 1);
      repeat (3) add(1'b1);
      chk_line("async line");
      under_clr();
    end
  endtask
  task automatic t_v14();
    start(16'h04d1);
    wr(OFS_TXDATA, 16'h005a);
    wr(OFS_TXDATA_ALT, 16'h00c3);
    rd(OFS_STATUS, s);
    chk("ready after write", 16'h0000, {15'h0, s[STAT_READY_BIT]});
    chk("holding full", 16'h0001, {15'h0, s[STAT_FULL_BIT]});
    for (int i = 0; i < 400 && s[STAT_READY_BIT] !== 1'b1; i++) rd(OFS_STATUS, s);
    chk("ready after move", 16'h0001, {15'h0, s[STAT_READY_BIT]});
    if (s[STAT_READY_BIT] !== 1'b1) give_verdict();
    wr(OFS_TXDATA, 16'h000f);
    frm(8'h5a, 8, 1'b0, 1'b0, 2);
    frm(8'hc3, 8, 1'b0, 1'b0, 1);
    frm(8'h0f, 8, 1'b0, 1'b0, 2);
    chk_line("dpsk stop drop");
    under_clr();
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    lk(3);
    t_regs();
    t_modes();
    t_pattern();
    t_sync();
    t_async();
    t_v14();
    give_verdict();
  end
endmodule
bind mtu_tx_usart mtu_tx_usart_sva chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx_mode_cfg(tx_mode_cfg), .rx_mode_cfg(rx_mode_cfg),
  .standby(standby), .clk_link(clk_link), .tx_bit(tx_bit), .tx_active(tx_active));
`default_nettype wire
